// file: hdl/i2c_status_defs.svh
// Offsets, field positions, reset values and counts of the status block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef I2C_STATUS_DEFS_SVH
`define I2C_STATUS_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_STATUS      4'h0
`define OFS_TXDATA      4'h4
`define OFS_RXDATA      4'h8

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define BIT_NACK        15
`define BIT_TX_PROG     14
`define BIT_ACK_WIN     13
`define BIT_BUS_COLL    10
`define BIT_GEN_CALL    9
`define BIT_TEN_BIT     8
`define BIT_WR_COLL     7
`define BIT_RX_OVF      6
`define BIT_DATA_ADDR   5
`define BIT_STOP_SEEN   4
`define BIT_START_SEEN  3
`define BIT_READ_XFER   2
`define BIT_RX_FULL     1
`define BIT_TX_FULL     0

// ----------------------------------------
// Reset values, answers and counts
// ----------------------------------------
`define STATUS_RESET    16'h0000
`define BYTE_RESET      8'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define ACK_EDGE_CNT    4'h8
`define CNT_ZERO        4'h0

`endif

// file: hdl/i2c_status_pkg.sv
// Types shared by the status block and its register port.
// Assumes the defs header is on the include path.
`include "i2c_status_defs.svh"

package i2c_status_pkg;

   // ----------------------------------------
   // Register selection
   // ----------------------------------------
   typedef enum logic [1:0] {
      SEL_STATUS = 2'h0,
      SEL_TXDATA = 2'h1,
      SEL_RXDATA = 2'h2,
      SEL_NONE   = 2'h3
   } reg_sel_e;

   typedef logic [1:0] axi_resp_t;

endpackage

// file: hdl/scl_edge_sync.sv
// Two-stage synchroniser and edge detector for the SCL pin.
// Assumes the pin is asynchronous to aclk.
module scl_edge_sync (
   input  wire logic aclk,      // Peripheral clock
   input  wire logic aresetn,   // Synchronous reset, active low
   input  wire logic scl_pin,   // Raw SCL level
   output logic      scl_rise,  // One-cycle pulse on rising edge
   output logic      scl_fall   // One-cycle pulse on falling edge
);

   logic meta_r;
   logic sync_r;
   logic last_r;

   // ----------------------------------------
   // Synchroniser chain
   // ----------------------------------------
   // Idle bus sits high, so reset to one avoids a false edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         last_r <= 1'b1;
      end else begin
         meta_r <= scl_pin;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   // Edges seen only after the second stage
   assign scl_rise = sync_r & ~last_r;
   assign scl_fall = ~sync_r & last_r;

endmodule // scl_edge_sync

// file: hdl/axil_regport.sv
// AXI4-Lite slave front end for the status block registers.
// Assumes the owner decodes addresses combinationally in the same cycle.
module axil_regport #(
   parameter int ADDR_W = 4
) (
   input  wire logic                      aclk,     // Peripheral clock
   input  wire logic                      aresetn,  // Synchronous reset, active low
   input  wire logic [ADDR_W-1:0]         awaddr,   // Write address
   input  wire logic                      awvalid,  // Write address valid
   output logic                           awready,  // Write address ready
   input  wire logic [31:0]               wdata,    // Write data
   input  wire logic [3:0]                wstrb,    // Write byte strobes
   input  wire logic                      wvalid,   // Write data valid
   output logic                           wready,   // Write data ready
   output i2c_status_pkg::axi_resp_t      bresp,    // Write response
   output logic                           bvalid,   // Write response valid
   input  wire logic                      bready,   // Write response ready
   input  wire logic [ADDR_W-1:0]         araddr,   // Read address
   input  wire logic                      arvalid,  // Read address valid
   output logic                           arready,  // Read address ready
   output logic [31:0]                    rdata,    // Read data
   output i2c_status_pkg::axi_resp_t      rresp,    // Read response
   output logic                           rvalid,   // Read data valid
   input  wire logic                      rready,   // Read data ready
   output logic                           wr_en,    // Commit write pulse
   output logic [ADDR_W-1:0]              wr_addr,  // Committed address
   output logic [31:0]                    wr_data,  // Committed data
   output logic [3:0]                     wr_strb,  // Committed strobes
   input  wire logic                      wr_err,   // Write address unmapped
   output logic                           rd_en,    // Read accept pulse
   input  wire logic [31:0]               rd_data,  // Read word
   input  wire logic                      rd_err    // Read address unmapped
);

   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic awready_r, wready_r, arready_r, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0]  wstrb_r, wstrb_nxt;
   i2c_status_pkg::axi_resp_t bresp_r, bresp_nxt, rresp_r, rresp_nxt;

   // Address and data may arrive in either order; commit waits for both
   assign wr_en   = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_addr = awaddr_r;
   assign wr_data = wdata_r;
   assign wr_strb = wstrb_r;
   assign rd_en   = arvalid & arready_r;

   // ----------------------------------------
   // Channel next state
   // ----------------------------------------
   always_comb begin
      aw_held_nxt = aw_held_r;
      awaddr_nxt  = awaddr_r;
      w_held_nxt  = w_held_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (awvalid && awready_r) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt  = awaddr;
      end
      if (wvalid && wready_r) begin
         w_held_nxt = 1'b1;
         wdata_nxt  = wdata;
         wstrb_nxt  = wstrb;
      end
      if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_en) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_en) begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = rd_data;
         rresp_nxt  = rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
   end

   // Ready flags registered so every bus output leaves a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
         w_held_r  <= 1'b0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= `RESP_OKAY;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         arready_r <= 1'b0;
      end else begin
         aw_held_r <= aw_held_nxt;
         awaddr_r  <= awaddr_nxt;
         w_held_r  <= w_held_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
         awready_r <= ~aw_held_nxt;
         wready_r  <= ~w_held_nxt;
         arready_r <= ~rvalid_nxt;
      end
   end

   assign awready = awready_r;
   assign wready  = wready_r;
   assign arready = arready_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;

endmodule // axil_regport

// file: hdl/i2c_status_flags.sv
// Status flags of an I2C controller behind an AXI4-Lite register port.
// Assumes the shift engine supplies one-cycle event pulses on aclk.
//
// Overview of operation
// - Master transmit: NACK sets, ACK clears the nack flag at acknowledge end.
// - Transmit-in-progress set at transmit start, cleared at acknowledge end.
// - Slave only: ack window rises on 8th SCL fall, drops on 9th rise.
// - Bus collision during master operation sets a sticky flag.
// - General call address match sets flag; Stop clears it.
// - Second byte 10-bit address match sets flag; Stop clears it.
// - Transmit write while busy is dropped and sets write-collision flag.
// - Byte arriving onto unread receive data sets the overflow flag.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`include "i2c_status_defs.svh"

module i2c_status_flags #(
   parameter int ADDR_W = 4
) (
   input  wire logic                 aclk,         // Peripheral clock
   input  wire logic                 aresetn,      // Synchronous reset, active low
   input  wire logic [ADDR_W-1:0]    awaddr,       // AXI write address
   input  wire logic                 awvalid,      // AXI
   output logic                      awready,      // AXI
   input  wire logic [31:0]          wdata,        // AXI write data
   input  wire logic [3:0]           wstrb,        // AXI byte strobes
   input  wire logic                 wvalid,       // AXI
   output logic                      wready,       // AXI
   output i2c_status_pkg::axi_resp_t bresp,        // AXI
   output logic                      bvalid,       // AXI
   input  wire logic                 bready,       // AXI
   input  wire logic [ADDR_W-1:0]    araddr,       // AXI read address
   input  wire logic                 arvalid,      // AXI
   output logic                      arready,      // AXI
   output logic [31:0]               rdata,        // AXI read data
   output i2c_status_pkg::axi_resp_t rresp,        // AXI
   output logic                      rvalid,       // AXI
   input  wire logic                 rready,       // AXI
   input  wire logic                 scl_pin,      // SCL line level
   input  wire logic                 master_mode,  // Engine acts as master
   input  wire logic                 slave_mode,   // Engine acts as slave
   input  wire logic                 tx_start,     // Master byte transmit begins
   input  wire logic                 ack_done,     // Master acknowledge bit ended
   input  wire logic                 ack_bit,      // Sampled ack, high is NACK
   input  wire logic                 coll_det,     // Bus collision seen
   input  wire logic                 start_det,    // Start condition seen
   input  wire logic                 stop_det,     // Stop condition seen
   input  wire logic                 gc_match,     // General call address seen
   input  wire logic                 addr10_match, // 10-bit second byte matched
   input  wire logic                 engine_busy,  // Engine cannot take data
   input  wire logic                 tx_taken,     // Engine took transmit byte
   input  wire logic                 rx_done,      // Shift register byte ready
   input  wire logic [7:0]           rx_byte,      // Shift register content
   input  wire logic                 last_was_data,// Last byte was data
   input  wire logic                 read_xfer,    // Current transfer is a read
   output logic [7:0]                tx_data,      // Byte for the engine
   output logic                      tx_load       // Pulse: new byte to send
);

   // Refused at elaboration: narrower address cannot reach 0x8
   if (ADDR_W < 4) begin : g_addr_check
      $error("ADDR_W must cover the register offsets");
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   logic              wr_en, rd_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data, rd_word;
   logic [3:0]        wr_strb;
   i2c_status_pkg::reg_sel_e wr_sel, rd_sel;

   // Shared offset decode for both directions
   function automatic i2c_status_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(`OFS_STATUS)) begin
         return i2c_status_pkg::SEL_STATUS;
      end else if (a == ADDR_W'(`OFS_TXDATA)) begin
         return i2c_status_pkg::SEL_TXDATA;
      end else if (a == ADDR_W'(`OFS_RXDATA)) begin
         return i2c_status_pkg::SEL_RXDATA;
      end
      return i2c_status_pkg::SEL_NONE;
   endfunction

   assign wr_sel = decode(wr_addr);
   assign rd_sel = decode(araddr);

   axil_regport #(.ADDR_W(ADDR_W)) u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_sel == i2c_status_pkg::SEL_NONE),
      .rd_en   (rd_en),
      .rd_data (rd_word),
      .rd_err  (rd_sel == i2c_status_pkg::SEL_NONE)
   );

   logic scl_rise, scl_fall;

   scl_edge_sync u_scl (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .scl_pin  (scl_pin),
      .scl_rise (scl_rise),
      .scl_fall (scl_fall)
   );

   // ----------------------------------------
   // Flag state
   // ----------------------------------------
   logic nack_r, nack_nxt, trs_r, trs_nxt, ackw_r, ackw_nxt;
   logic bcl_r, bcl_nxt, gc_r, gc_nxt, ten_r, ten_nxt;
   logic tx_write_collision_flag_r, tx_write_collision_flag_nxt, ov_r, ov_nxt, stop_r, stop_nxt, strt_r, strt_nxt;
   logic rbf_r, rbf_nxt, tbf_r, tbf_nxt, load_r, load_nxt;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] txd_r, txd_nxt, rxd_r, rxd_nxt;
   logic       sts_wr, tx_wr, rx_rd;
   logic [15:0] sts_word;

   // Write zero clears only when the owning byte lane is strobed
   assign sts_wr = wr_en && (wr_sel == i2c_status_pkg::SEL_STATUS);
   assign tx_wr  = wr_en && (wr_sel == i2c_status_pkg::SEL_TXDATA) && wr_strb[0];
   assign rx_rd  = rd_en && (rd_sel == i2c_status_pkg::SEL_RXDATA);

   function automatic logic sw_clr(input logic [31:0] d, input logic [3:0] s, input int b);
      return s[b / 8] && !d[b];
   endfunction

   // Software clears applied first so hardware sets win the same cycle
   always_comb begin
      nack_nxt    = nack_r;
      trs_nxt     = trs_r;
      ackw_nxt    = ackw_r;
      bcl_nxt     = bcl_r;
      gc_nxt      = gc_r;
      ten_nxt     = ten_r;
      tx_write_collision_flag_nxt   = tx_write_collision_flag_r;
      ov_nxt      = ov_r;
      stop_nxt    = stop_r;
      strt_nxt    = strt_r;
      rbf_nxt     = rbf_r;
      tbf_nxt     = tbf_r;
      txd_nxt     = txd_r;
      rxd_nxt     = rxd_r;
      load_nxt    = 1'b0;
      bit_cnt_nxt = bit_cnt_r;
      if (sts_wr) begin
         if (sw_clr(wr_data, wr_strb, `BIT_ACK_WIN))    ackw_nxt  = 1'b0;
         if (sw_clr(wr_data, wr_strb, `BIT_BUS_COLL))   bcl_nxt   = 1'b0;
         if (sw_clr(wr_data, wr_strb, `BIT_WR_COLL))    tx_write_collision_flag_nxt = 1'b0;
         if (sw_clr(wr_data, wr_strb, `BIT_RX_OVF))     ov_nxt    = 1'b0;
         if (sw_clr(wr_data, wr_strb, `BIT_STOP_SEEN))  stop_nxt  = 1'b0;
         if (sw_clr(wr_data, wr_strb, `BIT_START_SEEN)) strt_nxt  = 1'b0;
      end
      // Master transmit progress and acknowledge result
      if (master_mode && tx_start) begin
         trs_nxt = 1'b1;
      end
      if (master_mode && ack_done) begin
         nack_nxt = ack_bit;
         trs_nxt  = 1'b0;
      end
      // Slave ack window tracked by SCL edges since Start
      if (!slave_mode || start_det) begin
         bit_cnt_nxt = `CNT_ZERO;
         ackw_nxt    = 1'b0;
      end else if (scl_fall && bit_cnt_r == `ACK_EDGE_CNT) begin
         ackw_nxt = 1'b1;
      end else if (scl_rise) begin
         if (bit_cnt_r == `ACK_EDGE_CNT) begin
            bit_cnt_nxt = `CNT_ZERO;
            ackw_nxt    = 1'b0;
         end else begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
         end
      end
      if (master_mode && coll_det) begin
         bcl_nxt = 1'b1;
      end
      // Stop ends the address status; a match on the same cycle wins
      if (stop_det) begin
         gc_nxt   = 1'b0;
         ten_nxt  = 1'b0;
         stop_nxt = 1'b1;
         strt_nxt = 1'b0;
      end
      if (start_det) begin
         strt_nxt = 1'b1;
         stop_nxt = 1'b0;
      end
      if (gc_match) begin
         gc_nxt = 1'b1;
      end
      if (addr10_match) begin
         ten_nxt = 1'b1;
      end
      // Transmit path: a full buffer counts as busy too
      if (tx_taken) begin
         tbf_nxt = 1'b0;
      end
      if (tx_wr) begin
         if (engine_busy || tbf_r) begin
            tx_write_collision_flag_nxt = 1'b1;
         end else begin
            txd_nxt  = wr_data[7:0];
            tbf_nxt  = 1'b1;
            load_nxt = 1'b1;
         end
      end
      // Receive path: unread byte is kept, new byte dropped
      if (rx_rd) begin
         rbf_nxt = 1'b0;
      end
      if (rx_done) begin
         if (rbf_r && !rx_rd) begin
            ov_nxt = 1'b1;
         end else begin
            rxd_nxt = rx_byte;
            rbf_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nack_r    <= 1'b0;
         trs_r     <= 1'b0;
         ackw_r    <= 1'b0;
         bcl_r     <= 1'b0;
         gc_r      <= 1'b0;
         ten_r     <= 1'b0;
         tx_write_collision_flag_r   <= 1'b0;
         ov_r      <= 1'b0;
         stop_r    <= 1'b0;
         strt_r    <= 1'b0;
         rbf_r     <= 1'b0;
         tbf_r     <= 1'b0;
         load_r    <= 1'b0;
         bit_cnt_r <= `CNT_ZERO;
         txd_r     <= `BYTE_RESET;
         rxd_r     <= `BYTE_RESET;
      end else begin
         nack_r    <= nack_nxt;
         trs_r     <= trs_nxt;
         ackw_r    <= ackw_nxt;
         bcl_r     <= bcl_nxt;
         gc_r      <= gc_nxt;
         ten_r     <= ten_nxt;
         tx_write_collision_flag_r   <= tx_write_collision_flag_nxt;
         ov_r      <= ov_nxt;
         stop_r    <= stop_nxt;
         strt_r    <= strt_nxt;
         rbf_r     <= rbf_nxt;
         tbf_r     <= tbf_nxt;
         load_r    <= load_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         txd_r     <= txd_nxt;
         rxd_r     <= rxd_nxt;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Upper half and bits 12:11 read as zero
   always_comb begin
      sts_word                  = `STATUS_RESET;
      sts_word[`BIT_NACK]       = nack_r;
      sts_word[`BIT_TX_PROG]    = trs_r;
      sts_word[`BIT_ACK_WIN]    = ackw_r;
      sts_word[`BIT_BUS_COLL]   = bcl_r;
      sts_word[`BIT_GEN_CALL]   = gc_r;
      sts_word[`BIT_TEN_BIT]    = ten_r;
      sts_word[`BIT_WR_COLL]    = tx_write_collision_flag_r;
      sts_word[`BIT_RX_OVF]     = ov_r;
      sts_word[`BIT_DATA_ADDR]  = last_was_data;
      sts_word[`BIT_STOP_SEEN]  = stop_r;
      sts_word[`BIT_START_SEEN] = strt_r;
      sts_word[`BIT_READ_XFER]  = read_xfer;
      sts_word[`BIT_RX_FULL]    = rbf_r;
      sts_word[`BIT_TX_FULL]    = tbf_r;
      unique case (rd_sel)
         i2c_status_pkg::SEL_STATUS: rd_word = {16'h0000, sts_word};
         i2c_status_pkg::SEL_TXDATA: rd_word = {24'h000000, txd_r};
         i2c_status_pkg::SEL_RXDATA: rd_word = {24'h000000, rxd_r};
         i2c_status_pkg::SEL_NONE:   rd_word = 32'h00000000;
      endcase
   end

   assign tx_data = txd_r;
   assign tx_load = load_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_nack;
      master_mode && ack_done |=> nack_r == $past(ack_bit);
   endproperty
   a_nack: assert property (p_nack) else $error("nack flag wrong");

   property p_trs;
      master_mode && tx_start && !ack_done |=> trs_r throughout (!ack_done [*1]);
   endproperty
   a_trs: assert property (p_trs) else $error("transmit flag not set");

   property p_trs_end;
      master_mode && ack_done |=> !trs_r;
   endproperty
   a_trs_end: assert property (p_trs_end) else $error("transmit flag stuck");

   property p_ackw;
      slave_mode && !start_det && scl_fall && bit_cnt_r == 4'h8
      |=> ackw_r ##0 bit_cnt_r == 4'h8;
   endproperty
   a_ackw: assert property (p_ackw) else $error("ack window not raised");

   property p_ackw_end;
      slave_mode && !start_det && scl_rise && bit_cnt_r == 4'h8
      |=> !ackw_r && bit_cnt_r == 4'h0;
   endproperty
   a_ackw_end: assert property (p_ackw_end) else $error("ack window not dropped");

   property p_bcl;
      master_mode && coll_det |=> bcl_r ##1 ($stable(bcl_r) || $past(sts_wr));
   endproperty
   a_bcl: assert property (p_bcl) else $error("collision flag lost");

   property p_gc;
      stop_det && !gc_match |=> !gc_r;
   endproperty
   a_gc: assert property (p_gc) else $error("general call not cleared");

   property p_ten;
      addr10_match |=> ten_r;
   endproperty
   a_ten: assert property (p_ten) else $error("10-bit match not set");

   property p_tx_write_collision_flag;
      tx_wr && engine_busy |=> tx_write_collision_flag_r && !tx_load && $stable(tx_data);
   endproperty
   a_tx_write_collision_flag: assert property (p_tx_write_collision_flag) else $error("busy write not refused");

   property p_ov;
      rx_done && rbf_r && !rx_rd |=> ov_r && rbf_r && $stable(rxd_r);
   endproperty
   a_ov: assert property (p_ov) else $error("overflow not flagged");

   property p_ro;
      sts_wr && !master_mode && !gc_match && !stop_det |=> $stable(gc_r) && $stable(nack_r);
   endproperty
   a_ro: assert property (p_ro) else $error("read-only flag written");

endmodule // i2c_status_flags

// file: tb/scl_peer.sv
// Bus peer model that clocks one byte plus acknowledge on SCL.
// Assumes the bench raises go once; the line idles high outside the byte.
module scl_peer (
   input  wire logic aclk,     // Bench clock
   input  wire logic go,       // Begin one byte
   input  wire logic rel_low,  // Let the ninth clock rise
   output logic      scl       // SCL level seen by the design
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slow phases so every edge survives the two-flop sync; ninth low is stretched
   initial begin
      scl = 1'b1;
      wait (go);
      repeat (8) begin
         repeat (8) @(posedge aclk);
         scl <= 1'b0;
         repeat (8) @(posedge aclk);
         scl <= 1'b1;
      end
      repeat (8) @(posedge aclk);
      scl <= 1'b0;
      wait (rel_low);
      @(posedge aclk);
      scl <= 1'b1;
   end
endmodule  // scl_peer

// file: tb/testbench.sv
// Bench for the status flags: AXI4-Lite master tasks, engine pulses, SCL peer.
// Assumes the design answers every handshake; a watchdog cuts a hang short.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, rel_low;
   logic        master_mode, slave_mode, ack_bit, engine_busy, last_was_data, read_xfer;
   logic        awready, wready, bvalid, arready, rvalid, tx_load, scl_pin;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d, v;
   logic [7:0]  rx_byte, tx_data;
   logic [8:0]  ev;
   logic [1:0]  r;
   i2c_status_pkg::axi_resp_t bresp, rresp, b;
   wire         tx_start, ack_done, coll_det, start_det, stop_det, gc_match;
   wire         addr10_match, tx_taken, rx_done;
   int          err_count, cmp_count, loads;
   // Engine pulses share one vector so several can fire in one cycle
   assign {tx_start, ack_done, coll_det, start_det, stop_det, gc_match} = ev[8:3];
   assign {addr10_match, tx_taken, rx_done} = ev[2:0];
   i2c_status_flags dut (.*);
   scl_peer peer (.aclk(aclk), .go(go), .rel_low(rel_low), .scl(scl_pin));
   // Load pulses counted while they stand, one per accepted byte
   always @(posedge aclk) if (tx_load) loads++;
   // Expected register word for a byte-wide register
   function automatic logic [31:0] byte_word(input logic [7:0] x);
      return {24'h000000, x};
   endfunction
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic stop_test;
      if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Each channel released only at its own handshake edge
   task automatic wr(input logic [3:0] a, input logic [31:0] x);
      awaddr <= a;
      wdata <= x;
      wstrb <= 4'hF;
      {awvalid, wvalid, bready} <= 3'h7;
      fork
         @(posedge aclk iff awready) awvalid <= 1'b0;
         @(posedge aclk iff wready) wvalid <= 1'b0;
      join
      @(posedge aclk iff bvalid) b = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [3:0] a);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      @(posedge aclk iff arready) arvalid <= 1'b0;
      @(posedge aclk iff rvalid) {v, r} = {rdata, rresp};
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic st(input logic [31:0] e);
      rd(4'h0);
      chk("status", v, e);
   endtask
   task automatic pulse(input logic [8:0] m);
      ev <= m;
      @(posedge aclk);
      ev <= 9'h000;
      @(posedge aclk);
   endtask
   initial begin
      repeat (3000) @(posedge aclk);
      err_count++;
      stop_test;
   end
   initial begin
      {aresetn, master_mode, slave_mode, ack_bit, engine_busy, last_was_data} = '0;
      {read_xfer, go, rel_low, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, rx_byte, ev} = '0;
      void'($urandom(33));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      st(32'h0);
      rd(4'hC);
      chk("rresp", {30'h0, r}, 32'h2);
      wr(4'hC, 32'hFFFFFFFF);
      chk("bresp", {30'h0, b}, 32'h2);
      master_mode <= 1'b1;
      pulse(9'h100);
      st(32'h4000);
      ack_bit <= 1'b1;
      pulse(9'h080);
      st(32'h8000);
      pulse(9'h040);
      st(32'h8400);
      wr(4'h0, 32'h0);
      chk("bresp", {30'h0, b}, 32'h0);
      st(32'h8000);
      ack_bit <= 1'b0;
      pulse(9'h080);
      master_mode <= 1'b0;
      pulse(9'h040);
      st(32'h0);
      pulse(9'h00C);
      st(32'h0300);
      pulse(9'h010);
      st(32'h0010);
      wr(4'h0, 32'h0);
      d = $urandom;
      wr(4'h4, d);
      wr(4'h4, ~d);
      st(32'h0081);
      chk("tx_data", byte_word(tx_data), byte_word(d[7:0]));
      pulse(9'h002);
      wr(4'h0, 32'h0);
      engine_busy <= 1'b1;
      wr(4'h4, d);
      rx_byte <= d[15:8];
      pulse(9'h001);
      rx_byte <= d[23:16];
      pulse(9'h001);
      st(32'h00C2);
      rd(4'h8);
      chk("rx_data", v, byte_word(d[15:8]));
      chk("tx_load", loads, 32'h1);
      wr(4'h0, 32'h0);
      st(32'h0);
      slave_mode <= 1'b1;
      pulse(9'h020);
      go <= 1'b1;
      repeat (170) @(posedge aclk);
      st(32'h2008);
      rel_low <= 1'b1;
      repeat (10) @(posedge aclk);
      st(32'h0008);
      stop_test;
   end
endmodule  // testbench
